// File: hdl/fhb_apb_regs.sv
// APB slave holding the controller's own registers.
`timescale 1ns/1ps
module fhb_apb_regs (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core side
  output logic             go_pulse,
  output logic             op_write,
  output logic             op_reset,
  output logic      [19:0] op_addr,
  output logic      [15:0] op_wdata,
  input  wire logic [15:0] rd_data,
  input  wire logic        busy,
  input  wire logic        dev_ready,
  input  wire logic        done_set
);
  logic        wr_r, wr_nxt, rst_r, rst_nxt, done_r, done_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [15:0] wd_r, wd_nxt;
  logic [31:0] prd_r, prd_nxt;
  logic        err_r, err_nxt;
  logic        acc;

  assign acc      = psel & penable;
  // A frozen slave holds the transfer rather than dropping it.
  assign pready   = clk_en;
  assign prdata   = prd_r;
  assign pslverr  = err_r;
  // A GO write carries its own direction and reset bits.
  assign op_write = go_pulse ? pwdata[fhb_pkg::CTRL_WRITE_BIT] : wr_r;
  assign op_reset = go_pulse ? pwdata[fhb_pkg::CTRL_RESET_BIT] : rst_r;
  assign op_addr  = addr_r;
  assign op_wdata = wd_r;
  assign go_pulse = clk_en & acc & pwrite & (paddr == fhb_pkg::REG_CTRL)
                    & pwdata[fhb_pkg::CTRL_GO_BIT] & ~busy;

  always_comb begin
    wr_nxt   = wr_r;
    rst_nxt  = rst_r;
    addr_nxt = addr_r;
    wd_nxt   = wd_r;
    prd_nxt  = 32'h0000_0000;
    err_nxt  = 1'b0;
    // Done is sticky; a new completion wins over the read that clears it.
    done_nxt = done_r | done_set;
    if (psel & ~penable) begin
      if (paddr == fhb_pkg::REG_CTRL) begin
        prd_nxt = {29'h0, rst_r, wr_r, 1'b0};
      end else if (paddr == fhb_pkg::REG_ADDR) begin
        prd_nxt = {12'h000, addr_r};
      end else if (paddr == fhb_pkg::REG_WDATA) begin
        prd_nxt = {16'h0000, wd_r};
      end else if (paddr == fhb_pkg::REG_RDATA) begin
        prd_nxt = {16'h0000, rd_data};
      end else if (paddr == fhb_pkg::REG_STATUS) begin
        prd_nxt = {29'h0, done_r, dev_ready, busy};
        if (!pwrite) begin
          done_nxt = done_set;
        end
      end else begin
        err_nxt = 1'b1;
      end
    end
    if (acc & pwrite) begin
      if (paddr == fhb_pkg::REG_CTRL) begin
        if (!busy) begin
          wr_nxt  = pwdata[fhb_pkg::CTRL_WRITE_BIT];
          rst_nxt = pwdata[fhb_pkg::CTRL_RESET_BIT];
        end
      end else if (paddr == fhb_pkg::REG_ADDR) begin
        addr_nxt = pwdata[19:0];
      end else if (paddr == fhb_pkg::REG_WDATA) begin
        wd_nxt = pwdata[15:0];
      end
    end
    if (acc) begin
      err_nxt = err_r;
      prd_nxt = prd_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r   <= 1'b0;
      rst_r  <= 1'b0;
      done_r <= 1'b0;
      addr_r <= 20'h00000;
      wd_r   <= 16'h0000;
      prd_r  <= 32'h0000_0000;
      err_r  <= 1'b0;
    end else if (clk_en) begin
      wr_r   <= wr_nxt;
      rst_r  <= rst_nxt;
      done_r <= done_nxt;
      addr_r <= addr_nxt;
      wd_r   <= wd_nxt;
      prd_r  <= prd_nxt;
      err_r  <= err_nxt;
    end
  end
endmodule : fhb_apb_regs

// File: hdl/fhb_ctrl.sv
// Host-side controller that drives the flash bus pins from APB orders.
//
// Functional notes
// RULE1 - Device refuses alteration with program supply at or below lockout.
// RULE2 - Erase, write and lock need a two-step command sequence.
// RULE3 - Device disables writes while reset_powerdown_n is low.
// RULE4 - Block lock-bits gate erase and write.
// RULE5 - Reads work at any program supply level.
// RULE6 - After power-up or reset the device is in read-array mode.
// RULE7 - Read: chip select and output enable low, strobe and reset high.
// RULE8 - Output enable high tri-states the data lines.
// RULE9 - Chip select high means standby with data lines tri-stated.
// RULE10 - Deselecting mid operation does not stop the device.
// RULE11 - Reset low deselects and tri-states; hold it 100ns at least.
// RULE12 - Wait reset_wake_time after reset before reading data.
// RULE13 - Leaving reset gives read-array mode and status 80H.
// RULE14 - Reset during an operation aborts it, contents invalid.
// RULE15 - After such abort ready_busy_n stays low until reset ends.
// RULE16 - Wait reset_to_write_time after reset before writing commands.
// RULE17 - Drive reset_powerdown_n from the system reset.
// RULE18 - During an operation reads return status, not array data.
// RULE19 - Identifier mode returns maker, part, block and permanent codes.
// RULE20 - Identifier codes sit at 00000, 00001, block+2 and 00003.
// RULE21 - Host gives block, any or target address per command.
// RULE22 - Commands latch on the first rising edge of strobe or select.
`timescale 1ns/1ps
module fhb_ctrl #(
  parameter int WAKE_CYC   = fhb_pkg::WAKE_CYC,
  parameter int REC_CYC    = fhb_pkg::REC_CYC,
  parameter int STROBE_CYC = fhb_pkg::STROBE_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins
  output logic      [19:0] flash_addr,
  output logic             chip_sel_n,
  output logic             out_en_n,
  output logic             write_strobe_n,
  output logic             reset_powerdown_n,
  input  wire logic        ready_busy_n,
  input  wire logic [15:0] data_lines_in,
  output logic      [15:0] data_lines_out,
  output logic             data_lines_oe_n
);
  localparam int RST_CYC = fhb_pkg::RESET_LOW_CYC;
  localparam int CW = fhb_pkg::CNT_W;

  if (WAKE_CYC < 1 || REC_CYC < 1 || STROBE_CYC < 2 ||
      WAKE_CYC >= (1 << CW) || REC_CYC >= (1 << CW) ||
      STROBE_CYC >= (1 << CW) || RST_CYC >= (1 << CW)) begin : g_bad_counts
    $error("fhb_ctrl: cycle counts out of range");
  end

  logic        go_pulse, op_write, op_reset, done_set, busy;
  logic [19:0] op_addr;
  logic [15:0] op_wdata;

  fhb_pkg::fhb_state_t st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [15:0]   rd_r, rd_nxt;
  logic          wr_op_r, wr_op_nxt;
  logic [19:0]   fa_r, fa_nxt;
  logic [15:0]   fd_r, fd_nxt;
  logic          cs_r, cs_nxt, oe_r, oe_nxt, we_r, we_nxt;
  logic          rp_r, rp_nxt, doe_r, doe_nxt;
  logic [CW-1:0] rec_r, rec_nxt;

  fhb_apb_regs u_regs (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .go_pulse  (go_pulse),
    .op_write  (op_write),
    .op_reset  (op_reset),
    .op_addr   (op_addr),
    .op_wdata  (op_wdata),
    .rd_data   (rd_r),
    .busy      (busy),
    .dev_ready (ready_busy_n),
    .done_set  (done_set)
  );

  assign busy              = (st_r != fhb_pkg::ST_IDLE);
  assign flash_addr        = fa_r;
  assign chip_sel_n        = cs_r;
  assign out_en_n          = oe_r;
  assign write_strobe_n    = we_r;
  assign reset_powerdown_n = rp_r;
  assign data_lines_out    = fd_r;
  assign data_lines_oe_n   = doe_r;

  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    rd_nxt      = rd_r;
    wr_op_nxt   = wr_op_r;
    fa_nxt      = fa_r;
    fd_nxt      = fd_r;
    cs_nxt      = cs_r;
    oe_nxt      = oe_r;
    we_nxt      = we_r;
    rp_nxt      = rp_r;
    doe_nxt     = doe_r;
    rec_nxt     = rec_r;
    done_set    = 1'b0;
    // A single recovery timer after reset release gates reads and writes.
    if (rec_r != '0) begin
      rec_nxt = rec_r - 1'b1;
    end
    case (st_r)
      fhb_pkg::ST_IDLE: begin
        // Leaves the power-on reset on the first edge after release.
        rp_nxt = 1'b1;
        if (go_pulse) begin
          wr_op_nxt = op_write;
          fa_nxt    = op_addr; // [RULE21]
          fd_nxt    = op_wdata;
          cnt_nxt   = '0;
          if (op_reset) begin
            // Bus idle and drivers off during reset. [RULE11] [RULE17]
            rp_nxt  = 1'b0;
            cs_nxt  = 1'b1;
            oe_nxt  = 1'b1;
            we_nxt  = 1'b1;
            doe_nxt = 1'b1;
            st_nxt  = fhb_pkg::ST_RST;
          end else begin
            st_nxt = fhb_pkg::ST_WAKE;
          end
        end
      end
      fhb_pkg::ST_RST: begin
        // Hold reset at least the minimum low time. [RULE11]
        if (cnt_r >= CW'(RST_CYC - 1)) begin
          rp_nxt      = 1'b1;
          rec_nxt     = CW'(WAKE_CYC > REC_CYC ? WAKE_CYC : REC_CYC);
          done_set    = 1'b1;
          st_nxt      = fhb_pkg::ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      fhb_pkg::ST_WAKE: begin
        // Reads wait the wake time, writes the recovery time, both
        // counted from the release of reset. [RULE12] [RULE16]
        if (rec_r == '0 ||
            (!wr_op_r && rec_r <= CW'(REC_CYC > WAKE_CYC ?
                                      REC_CYC - WAKE_CYC : 0)) ||
            (wr_op_r && rec_r <= CW'(WAKE_CYC > REC_CYC ?
                                     WAKE_CYC - REC_CYC : 0))) begin
          cs_nxt  = 1'b0;
          st_nxt  = fhb_pkg::ST_SETUP;
        end
      end
      fhb_pkg::ST_SETUP: begin
        cnt_nxt = '0;
        if (wr_op_r) begin
          // One command word per strobe; software issues pairs. [RULE2]
          // Drive data on the same edge as the strobe falls. [RULE22]
          doe_nxt = 1'b0;
          we_nxt  = 1'b0;
        end else begin
          oe_nxt  = 1'b0; // [RULE7]
        end
        st_nxt = fhb_pkg::ST_STROBE;
      end
      fhb_pkg::ST_STROBE: begin
        if (cnt_r >= CW'(STROBE_CYC - 1)) begin
          if (wr_op_r) begin
            // Strobe rises first so it latches the command. [RULE22]
            we_nxt = 1'b1;
          end else begin
            // Status appears here while an operation runs. [RULE18]
            rd_nxt = data_lines_in;
            oe_nxt = 1'b1; // [RULE8]
          end
          st_nxt = fhb_pkg::ST_HOLD;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      fhb_pkg::ST_HOLD: begin
        // Deselect; a running operation continues. [RULE9] [RULE10]
        cs_nxt   = 1'b1;
        doe_nxt  = 1'b1;
        done_set = 1'b1;
        st_nxt   = fhb_pkg::ST_IDLE;
      end
      default: begin
        st_nxt = fhb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= fhb_pkg::ST_IDLE;
      cnt_r     <= '0;
      rd_r      <= 16'h0000;
      wr_op_r   <= 1'b0;
      fa_r      <= 20'h00000;
      fd_r      <= 16'h0000;
      cs_r      <= 1'b1;
      oe_r      <= 1'b1;
      we_r      <= 1'b1;
      // Device held in reset while the system is. [RULE17]
      rp_r      <= 1'b0;
      doe_r     <= 1'b1;
      rec_r     <= CW'(WAKE_CYC > REC_CYC ? WAKE_CYC : REC_CYC);
    end else if (clk_en) begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      rd_r      <= rd_nxt;
      wr_op_r   <= wr_op_nxt;
      fa_r      <= fa_nxt;
      fd_r      <= fd_nxt;
      cs_r      <= cs_nxt;
      oe_r      <= oe_nxt;
      we_r      <= we_nxt;
      rp_r      <= rp_nxt;
      doe_r     <= doe_nxt;
      rec_r     <= rec_nxt;
    end
  end
endmodule : fhb_ctrl

// File: hdl/fhb_pkg.sv
// Package with constants for the flash host bus controller.
package fhb_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  // Own register offsets on APB (byte addresses).
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // Control register fields.
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_RESET_BIT = 2;
  // Status register fields.
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_RDY_BIT   = 1;
  localparam int STAT_DONE_BIT  = 2;
  // Device identifier map (word addresses).
  localparam logic [19:0] ID_MAKER_ADDR     = 20'h00000;
  localparam logic [19:0] ID_PART_ADDR      = 20'h00001;
  localparam logic [19:0] ID_LAST_MAIN_ADDR = 20'h00002;
  localparam logic [19:0] ID_PERM_LOCK_ADDR = 20'h00003;
  localparam logic [19:0] ID_MAIN0_ADDR     = 20'hF0002;
  localparam logic [19:0] ID_PARAM5_ADDR    = 20'hF8002;
  localparam logic [19:0] ID_PARAM0_ADDR    = 20'hFD002;
  localparam logic [19:0] ID_BOOT1_ADDR     = 20'hFE002;
  localparam logic [19:0] ID_BOOT0_ADDR     = 20'hFF002;
  localparam logic [7:0]  STATUS_AFTER_RESET = 8'h80;
  // Timing, in ns, and derived cycle counts at 4 ns.
  localparam int CLK_PERIOD_NS   = 4;
  localparam int RESET_LOW_NS    = 100;
  localparam int RESET_LOW_CYC   = (RESET_LOW_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int WAKE_NS         = 100;
  localparam int WAKE_CYC        = (WAKE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int REC_NS          = 100;
  localparam int REC_CYC         = (REC_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int STROBE_NS       = 100;
  localparam int STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RST, ST_WAKE, ST_SETUP, ST_STROBE, ST_HOLD
  } fhb_state_t;
endpackage : fhb_pkg

// File: tb/fhb_ctrl_assertions.sv
// Pin checks bound to the flash host bus controller.
`timescale 1ns/1ps
module fhb_ctrl_assertions #(
  parameter int WAKE_CYC   = 25,
  parameter int REC_CYC    = 25,
  parameter int STROBE_CYC = 25
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Flash pins
  input wire logic [19:0] flash_addr,
  input wire logic        chip_sel_n,
  input wire logic        out_en_n,
  input wire logic        write_strobe_n,
  input wire logic        reset_powerdown_n,
  input wire logic [15:0] data_lines_out,
  input wire logic        data_lines_oe_n
);
  localparam int GAP = (WAKE_CYC > REC_CYC ? WAKE_CYC : REC_CYC) - 1;
  logic [7:0] lo_r, lo_nxt, hi_r, hi_nxt, we_r, we_nxt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Saturating counts, so long idle spans never wrap back to zero.
  always_comb begin
    lo_nxt = reset_powerdown_n ? 8'h00 : lo_r + 8'(lo_r != 8'hFF);
    hi_nxt = reset_powerdown_n ? hi_r + 8'(hi_r != 8'hFF) : 8'h00;
    we_nxt = write_strobe_n ? 8'h00 : we_r + 8'(we_r != 8'hFF);
  end
  // Power-on release is timed by the system reset, so it counts as long.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_r <= 8'hFF;
      hi_r <= 8'h00;
      we_r <= 8'h00;
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      we_r <= we_nxt;
    end
  end
  read_pins_a: assert property (!out_en_n |-> !chip_sel_n
    && write_strobe_n && reset_powerdown_n) else $error("bad read pins");
  write_pins_a: assert property (!write_strobe_n |-> !chip_sel_n
    && out_en_n && !data_lines_oe_n) else $error("bad write pins");
  no_fight_a: assert property (!data_lines_oe_n |-> out_en_n)
    else $error("data driven while device may drive");
  standby_quiet_a: assert property (chip_sel_n |-> out_en_n
    && write_strobe_n) else $error("strobe while deselected");
  reset_quiet_a: assert property (!reset_powerdown_n |-> chip_sel_n
    && write_strobe_n) else $error("access during reset");
  reset_width_a: assert property ($rose(reset_powerdown_n) |->
    int'(lo_r) >= fhb_pkg::RESET_LOW_CYC) else $error("reset too short");
  wake_gap_a: assert property ($fell(chip_sel_n) |->
    int'(hi_r) >= GAP) else $error("access too soon after reset");
  strobe_width_a: assert property ($rose(write_strobe_n) |->
    int'(we_r) >= STROBE_CYC) else $error("write strobe too short");
  latch_hold_a: assert property ($rose(write_strobe_n) |->
    !chip_sel_n && $stable(flash_addr) && $stable(data_lines_out)
    ##1 chip_sel_n) else $error("latch edge not by strobe");
  cover property ($fell(out_en_n));
  cover property ($fell(write_strobe_n));
  cover property ($rose(reset_powerdown_n) && lo_r != 8'hFF);
endmodule : fhb_ctrl_assertions

bind fhb_ctrl fhb_ctrl_assertions #(
  .WAKE_CYC  (WAKE_CYC),
  .REC_CYC   (REC_CYC),
  .STROBE_CYC(STROBE_CYC)
) u_fhb_chk (
  .ref_clk, .rst_n, .flash_addr, .chip_sel_n, .out_en_n,
  .write_strobe_n, .reset_powerdown_n, .data_lines_out, .data_lines_oe_n
);

// File: tb/fhb_ctrl_bench.sv
// Self-checking bench driving the controller over APB.
`timescale 1ns/1ps
module fhb_ctrl_bench;
  localparam logic [31:0] RD = 32'h1 << fhb_pkg::CTRL_GO_BIT;
  localparam logic [31:0] WR = RD | 32'h1 << fhb_pkg::CTRL_WRITE_BIT;
  localparam logic [31:0] RS = RD | 32'h1 << fhb_pkg::CTRL_RESET_BIT;
  localparam logic [15:0] SETUP = 16'h0040, IDENT = 16'h0090;
  localparam logic [15:0] MAKER = 16'h5A01, PART = 16'h5A02;
  logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, ev, pready, pslverr, chip_sel_n, out_en_n;
  logic        write_strobe_n, reset_powerdown_n, ready_busy_n;
  logic        data_lines_oe_n;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [19:0] flash_addr;
  logic [15:0] data_lines, data_lines_out, dev_out;
  logic [19:0] id_a [6] = '{20'h00000, 20'h00001, 20'h00002, 20'h00003,
                            20'hF8002, 20'hFF002};
  logic [15:0] id_e [6] = '{MAKER, PART, 16'h0, 16'h0, 16'h0, 16'h0};
  int          n_fail = 0, comparisons = 0;
  always #2 ref_clk = ~ref_clk;
  assign data_lines = (data_lines_oe_n === 1'b0) ? data_lines_out : dev_out;
  fhb_ctrl #(.WAKE_CYC(6), .REC_CYC(5), .STROBE_CYC(3)) DUT (
    .ref_clk, .rst_n, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .flash_addr, .chip_sel_n,
    .out_en_n, .write_strobe_n, .reset_powerdown_n, .ready_busy_n,
    .data_lines_in(data_lines), .data_lines_out, .data_lines_oe_n
  );
  fhb_flash_model #(.SETUP(SETUP), .IDENT(IDENT), .MAKER_ID(MAKER),
                    .PART_ID(PART), .LOCKED(16'h0080)) u_dev (
    .flash_addr, .chip_sel_n, .out_en_n, .write_strobe_n,
    .reset_powerdown_n, .ready_busy_n, .data_lines_in(data_lines),
    .data_lines_out(dev_out)
  );
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // Entered just after a rising edge; leaves one idle edge behind it.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic fop(input logic [31:0] op, input logic [19:0] a,
                     input logic [15:0] d);
    apb(1'b1, fhb_pkg::REG_ADDR, {12'h000, a});
    apb(1'b1, fhb_pkg::REG_WDATA, {16'h0000, d});
    apb(1'b1, fhb_pkg::REG_CTRL, op);
    rv = 32'h0;
    while (rv[fhb_pkg::STAT_DONE_BIT] !== 1'b1)
      apb(1'b0, fhb_pkg::REG_STATUS, 32'h0);
    apb(1'b0, fhb_pkg::REG_RDATA, 32'h0);
  endtask : fop
  task automatic end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, fhb_pkg::REG_STATUS, 32'h0);
    chk("status", rv, 32'h1 << fhb_pkg::STAT_RDY_BIT);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {31'h0, ev}, 32'h1);
    chk("unmapped data", rv, 32'h0);
    fop(RD, 20'h00005, 16'h0);
    chk("array", rv, 32'h1005);
    fop(WR, 20'h00000, IDENT);
    for (int i = 0; i < 6; i++) begin
      fop(RD, id_a[i], 16'h0);
      chk("ident", rv, {16'h0, id_e[i]});
    end
    fop(WR, 20'h00000, 16'h00FF);
    fop(WR, 20'h00005, SETUP);
    fop(WR, 20'h00005, 16'hBEEF);
    fop(RD, 20'h00005, 16'h0);
    chk("busy read", rv, 32'h0);
    apb(1'b0, fhb_pkg::REG_STATUS, 32'h0);
    chk("busy pin", {31'h0, rv[fhb_pkg::STAT_RDY_BIT]}, 32'h0);
    while (rv[fhb_pkg::STAT_RDY_BIT] !== 1'b1)
      apb(1'b0, fhb_pkg::REG_STATUS, 32'h0);
    fop(RD, 20'h00005, 16'h0);
    chk("written", rv, 32'hBEEF);
    fop(WR, 20'h00007, SETUP);
    fop(WR, 20'h00007, 16'h7777);
    fop(RD, 20'h00007, 16'h0);
    chk("locked", rv, 32'h1007);
    fop(WR, 20'h00006, SETUP);
    fop(WR, 20'h00006, 16'h1234);
    fop(RS, 20'h00000, 16'h0);
    fop(RD, 20'h00006, 16'h0);
    chk("aborted", rv, 32'h1006);
    end_sim;
  end
  // Several times the expected run; a hang counts as a failure.
  initial begin
    #20000;
    n_fail++;
    end_sim;
  end
endmodule : fhb_ctrl_bench

// File: tb/fhb_flash_model.sv
// Behavioural flash device answering the controller's pins.
`timescale 1ns/1ps
module fhb_flash_model #(
  parameter int          BUSY_NS  = 600,
  parameter bit          SUPPLY_OK = 1'b1,
  parameter logic [15:0] LOCKED   = 16'h0000,
  parameter logic [15:0] SETUP    = 16'h0040,
  parameter logic [15:0] IDENT    = 16'h0090,
  parameter logic [15:0] MAKER_ID = 16'h5A01, // Arbitrary value.
  parameter logic [15:0] PART_ID  = 16'h5A02  // Arbitrary value.
) (
  // Bus pins
  input  wire logic [19:0] flash_addr,
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic        write_strobe_n,
  input  wire logic        reset_powerdown_n,
  output logic             ready_busy_n,
  // Board level of the data lines and this device's own drive
  input  wire logic [15:0] data_lines_in,
  output logic      [15:0] data_lines_out
);
  logic [15:0] mem [16];
  logic [15:0] stat_r = 16'h0080, rd_w, last_r = 16'h0000, pend_d;
  logic [3:0]  pend_a;
  logic        busy_r = 1'b0, setup_r = 1'b0, ident_r = 1'b0, drive;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'h1000 + 16'(i);
  end
  task automatic take(input logic [19:0] a, input logic [15:0] d);
    if (!reset_powerdown_n || busy_r) return;
    if (setup_r) begin
      setup_r = 1'b0;
      pend_a = a[3:0];
      pend_d = d;
      // Low supply or a locked word refuses the change.
      busy_r = SUPPLY_OK && !LOCKED[a[3:0]];
      stat_r = busy_r ? 16'h0000 : 16'h0080;
    end else begin
      setup_r = (d == SETUP);
      ident_r = (d == IDENT);
    end
  endtask : take
  always @(posedge write_strobe_n)
    if (!chip_sel_n) take(flash_addr, data_lines_in);
  always @(posedge chip_sel_n)
    if (!write_strobe_n) take(flash_addr, data_lines_in);
  always @(negedge reset_powerdown_n) begin
    busy_r = 1'b0;
    setup_r = 1'b0;
    ident_r = 1'b0;
    stat_r = 16'h0080;
  end
  // A reset clears busy before the wait ends, so aborted data is lost.
  always begin
    wait (busy_r);
    #(BUSY_NS);
    if (busy_r) mem[pend_a] = pend_d;
    busy_r = 1'b0;
    stat_r = 16'h0080;
  end
  assign ready_busy_n = reset_powerdown_n && !busy_r;
  always @* begin
    rd_w = mem[flash_addr[3:0]];
    if (busy_r) rd_w = stat_r;
    else if (ident_r) begin
      rd_w = 16'hFFFF;
      if (flash_addr == 20'h00000) rd_w = MAKER_ID;
      if (flash_addr == 20'h00001) rd_w = PART_ID;
      if (flash_addr[11:0] == 12'h002 || flash_addr == 20'h00003)
        rd_w = 16'h0000;
    end
  end
  assign drive = !chip_sel_n && !out_en_n && write_strobe_n
                 && reset_powerdown_n;
  // Released lines show the inverse of their last value, never a hold.
  assign data_lines_out = drive ? rd_w : ~last_r;
  always @(data_lines_out) if (drive) last_r = data_lines_out;
endmodule : fhb_flash_model
